/* File: rtl/ltm_regs.svh */
// Register offsets, field positions and timing constants of the latency timer.
`ifndef LTM_TIMER_REGS_SVH
`define LTM_TIMER_REGS_SVH
// ==========================================================
// Register offsets (byte addresses)
`define LTM_OFF_IDLE_FAST   8'he0
`define LTM_OFF_IDLE_SLOW   8'he4
`define LTM_OFF_ACT_FAST    8'he8
`define LTM_OFF_ACT_SLOW    8'hec
`define LTM_OFF_INACT_FAST  8'hf0
`define LTM_OFF_INACT_SLOW  8'hf4
`define LTM_OFF_CTRL        8'hf8
`define LTM_OFF_STATUS      8'hfc
// ==========================================================
// Field layout
`define LTM_TOL_W           12
`define LTM_REL_W           16
`define LTM_HI_LSB          16
`define LTM_LO_LSB          0
`define LTM_CTRL_EN_BIT     0
`define LTM_STAT_CNT_LSB    0
`define LTM_STAT_COUNT_BIT  16
`define LTM_STAT_LOW_BIT    17
`define LTM_RESET_VALUE     32'h0000_0000
// ==========================================================
// Timing
`define LTM_TICK_US         100
`define LTM_CLK_MHZ         100
`endif

/* File: rtl/ltm_pkg.sv */
// Types shared by the latency inactivity timer and its surroundings.
`default_nettype none
package ltm_pkg;
    // Ethernet link speed as reported by the MAC.
    typedef enum logic [1:0] {SPD_10M, SPD_100M, SPD_1G} speed_e;
    // Latency state machine.
    typedef enum logic [1:0] {ST_BUSY, ST_COUNT, ST_LOWPWR} state_e;
    // Tolerance and reload image, as stored and as loaded from EEPROM/OTP.
    typedef struct packed {
        logic [11:0] idleTol1g;
        logic [11:0] idleTol100m;
        logic [11:0] idleTol10m;
        logic [11:0] activeTol1g;
        logic [11:0] activeTol100m;
        logic [11:0] activeTol10m;
        logic [15:0] inactivityReload1g;
        logic [15:0] inactivityReload100m;
        logic [15:0] inactivityReload10m;
    } ltm_image_s;
    // Emptiness of the four data path FIFOs and bulk-out pending flag.
    typedef struct packed {
        logic usbTxSideFifoEmpty;
        logic usbRxSideFifoEmpty;
        logic frameRxFifoEmpty;
        logic frameTxFifoEmpty;
        logic bulkOutPending;
    } datapath_s;
endpackage
`default_nettype wire

/* File: rtl/ltm_latency_inactivity_timer.sv */
// Latency tolerance selection and inactivity countdown with an APB register file.
`timescale 1ns/1ps
`default_nettype none
`include "ltm_regs.svh"

// What this block does
// - Keep a writable 12-bit idle tolerance for 10 Mbps in bits 11:0.
// - Keep writable active tolerances: 1 Gbps in 27:16, 100 Mbps in 11:0.
// - Keep writable active 10 Mbps tolerance in 11:0 and use it at 10 Mbps.
// - Load the countdown by speed when enabled, FIFOs empty, no bulk-out pending.
// - Count down from the loaded value; at zero enter the idle latency state.
// - Each countdown step lasts 100 microseconds.
// - At gigabit speed reload from bits 31:16 of the first timer register.
// - At 100 Mbps reload from bits 15:0 of the first timer register.
// - At 10 Mbps reload from bits 15:0 of the second timer register.
// - Keep idle tolerances for 1 Gbps and 100 Mbps and select by speed.
// - USB or lite reset restores the tolerance and reload fields from the image, else zero.
module ltm_latency_inactivity_timer #(
    parameter int TICK_CYCLES = `LTM_TICK_US * `LTM_CLK_MHZ
) (
    input  wire logic               clock,          // 100 MHz clock.
    input  wire logic               rst,            // Synchronous reset, active high.
    input  wire logic               psel,           // APB select.
    input  wire logic               penable,        // APB access phase.
    input  wire logic               pwrite,         // APB direction, high for write.
    input  wire logic [7:0]         paddr,          // APB byte address.
    input  wire logic [31:0]        pwdata,         // APB write data.
    output logic      [31:0]        prdata,         // APB read data.
    output logic                    pready,         // APB ready.
    output logic                    pslverr,        // APB error on unmapped address.
    input  wire logic               usbReset,       // USB reset pulse.
    input  wire logic               liteReset,      // Lite reset pulse.
    input  wire logic               imageValid,     // Image was loaded from EEPROM/OTP.
    input  wire ltm_pkg::ltm_image_s image,         // Last loaded image.
    input  wire ltm_pkg::datapath_s dataPath,       // FIFO and bulk-out status.
    input  wire ltm_pkg::speed_e    linkSpeed,      // Current Ethernet speed.
    output logic                    lowPower,       // High in the idle latency state.
    output logic      [11:0]        tolerance       // Selected tolerance value.
);
    import ltm_pkg::*;

    localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

    // ==========================================================
    // Register file
    ltm_image_s  cfg_q, cfg_d;
    logic        enable_q, enable_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic        restore;
    logic        wrAccept;
    logic        mapped;
    logic [31:0] readWord;

    // ==========================================================
    // Timer state
    state_e      state_q, state_d;
    logic [15:0] count_q, count_d;
    logic [TW-1:0] tickCnt_q, tickCnt_d;
    logic        tick;
    logic        allIdle;
    logic [15:0] reload;
    logic        lowPower_q, lowPower_d;
    logic [11:0] tol_q, tol_d;

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign lowPower  = lowPower_q;
    assign tolerance = tol_q;

    // Either reset flavour restores the image; neither touches the state of the bus.
    assign restore  = usbReset | liteReset;
    assign wrAccept = psel & penable & pready_q & pwrite;

    // Address decode and read mux; reserved bits read as zero.
    always_comb begin
        mapped   = 1'b1;
        readWord = 32'h0000_0000;
        unique case (paddr)
            `LTM_OFF_IDLE_FAST: begin
                readWord[`LTM_HI_LSB +: `LTM_TOL_W] = cfg_q.idleTol1g;
                readWord[`LTM_LO_LSB +: `LTM_TOL_W] = cfg_q.idleTol100m;
            end
            `LTM_OFF_IDLE_SLOW: begin
                readWord[`LTM_LO_LSB +: `LTM_TOL_W] = cfg_q.idleTol10m;
            end
            `LTM_OFF_ACT_FAST: begin
                readWord[`LTM_HI_LSB +: `LTM_TOL_W] = cfg_q.activeTol1g;
                readWord[`LTM_LO_LSB +: `LTM_TOL_W] = cfg_q.activeTol100m;
            end
            `LTM_OFF_ACT_SLOW: begin
                readWord[`LTM_LO_LSB +: `LTM_TOL_W] = cfg_q.activeTol10m;
            end
            `LTM_OFF_INACT_FAST: begin
                readWord[`LTM_HI_LSB +: `LTM_REL_W] = cfg_q.inactivityReload1g;
                readWord[`LTM_LO_LSB +: `LTM_REL_W] = cfg_q.inactivityReload100m;
            end
            `LTM_OFF_INACT_SLOW: begin
                readWord[`LTM_LO_LSB +: `LTM_REL_W] = cfg_q.inactivityReload10m;
            end
            `LTM_OFF_CTRL: begin
                readWord[`LTM_CTRL_EN_BIT] = enable_q;
            end
            `LTM_OFF_STATUS: begin
                readWord[`LTM_STAT_CNT_LSB +: `LTM_REL_W] = count_q;
                readWord[`LTM_STAT_COUNT_BIT] = (state_q == ST_COUNT);
                readWord[`LTM_STAT_LOW_BIT]   = (state_q == ST_LOWPWR);
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // APB handshake: ready is raised in the second access cycle, so every
    // transfer takes one wait state; this keeps all bus outputs registered.
    always_comb begin
        pready_d  = 1'b0;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (psel && penable && !pready_q) begin
            pready_d  = 1'b1;
            pslverr_d = ~mapped;
            prdata_d  = pwrite ? 32'h0000_0000 : readWord;
        end
    end

    // Register writes; the status register and unmapped words ignore writes.
    always_comb begin
        cfg_d    = cfg_q;
        enable_d = enable_q;
        if (wrAccept) begin
            unique case (paddr)
                `LTM_OFF_IDLE_FAST: begin
                    cfg_d.idleTol1g   = pwdata[`LTM_HI_LSB +: `LTM_TOL_W];
                    cfg_d.idleTol100m = pwdata[`LTM_LO_LSB +: `LTM_TOL_W];
                end
                `LTM_OFF_IDLE_SLOW: begin
                    cfg_d.idleTol10m = pwdata[`LTM_LO_LSB +: `LTM_TOL_W];
                end
                `LTM_OFF_ACT_FAST: begin
                    cfg_d.activeTol1g   = pwdata[`LTM_HI_LSB +: `LTM_TOL_W];
                    cfg_d.activeTol100m = pwdata[`LTM_LO_LSB +: `LTM_TOL_W];
                end
                `LTM_OFF_ACT_SLOW: begin
                    cfg_d.activeTol10m = pwdata[`LTM_LO_LSB +: `LTM_TOL_W];
                end
                `LTM_OFF_INACT_FAST: begin
                    cfg_d.inactivityReload1g   = pwdata[`LTM_HI_LSB +: `LTM_REL_W];
                    cfg_d.inactivityReload100m = pwdata[`LTM_LO_LSB +: `LTM_REL_W];
                end
                `LTM_OFF_INACT_SLOW: begin
                    cfg_d.inactivityReload10m = pwdata[`LTM_LO_LSB +: `LTM_REL_W];
                end
                `LTM_OFF_CTRL: begin
                    enable_d = pwdata[`LTM_CTRL_EN_BIT];
                end
                default: begin
                end
            endcase
        end
        // A reset event beats a tolerance or reload write landing in the same cycle; an enable write still lands.
        if (restore) begin
            cfg_d = imageValid ? image : ltm_image_s'(`LTM_RESET_VALUE);
        end
    end

    // Register file flops.
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_q     <= ltm_image_s'(`LTM_RESET_VALUE);
            enable_q  <= 1'b0;
            prdata_q  <= `LTM_RESET_VALUE;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            cfg_q     <= cfg_d;
            enable_q  <= enable_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ==========================================================
    // Inactivity countdown
    // The data path counts as idle only with messaging on and nothing queued.
    assign allIdle = enable_q
                   & dataPath.usbTxSideFifoEmpty
                   & dataPath.usbRxSideFifoEmpty
                   & dataPath.frameRxFifoEmpty
                   & dataPath.frameTxFifoEmpty
                   & ~dataPath.bulkOutPending;

    // Reload value chosen by the current link speed.
    always_comb begin
        unique case (linkSpeed)
            SPD_1G:   reload = cfg_q.inactivityReload1g;
            SPD_100M: reload = cfg_q.inactivityReload100m;
            SPD_10M:  reload = cfg_q.inactivityReload10m;
            default:  reload = cfg_q.inactivityReload1g;
        endcase
    end

    // The step divider restarts on every load so the first step is a full one.
    assign tick = (tickCnt_q == TW'(TICK_CYCLES - 1));

    always_comb begin
        state_d   = state_q;
        count_d   = count_q;
        tickCnt_d = tick ? '0 : tickCnt_q + 1'b1;
        unique case (state_q)
            ST_BUSY: begin
                if (allIdle) begin
                    state_d   = ST_COUNT;
                    count_d   = reload;
                    tickCnt_d = '0;
                end
            end
            ST_COUNT: begin
                if (!allIdle) begin
                    state_d = ST_BUSY;
                end else if (count_q == 16'h0000) begin
                    state_d = ST_LOWPWR;
                end else if (tick) begin
                    count_d = count_q - 16'h0001;
                end
            end
            ST_LOWPWR: begin
                if (!allIdle) begin
                    state_d = ST_BUSY;
                end
            end
            default: begin
                state_d = ST_BUSY;
            end
        endcase
        // Reset events drop any countdown in progress.
        if (restore) begin
            state_d = ST_BUSY;
        end
    end

    // Tolerance selection by latency state and link speed, registered once.
    always_comb begin
        lowPower_d = (state_d == ST_LOWPWR);
        unique case (linkSpeed)
            SPD_1G: begin
                tol_d = (state_q == ST_LOWPWR) ? cfg_q.idleTol1g
                                               : cfg_q.activeTol1g;
            end
            SPD_100M: begin
                tol_d = (state_q == ST_LOWPWR) ? cfg_q.idleTol100m
                                               : cfg_q.activeTol100m;
            end
            SPD_10M: begin
                tol_d = (state_q == ST_LOWPWR) ? cfg_q.idleTol10m
                                               : cfg_q.activeTol10m;
            end
            default: begin
                tol_d = cfg_q.activeTol1g;
            end
        endcase
    end

    // Timer flops.
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q    <= ST_BUSY;
            count_q    <= 16'h0000;
            tickCnt_q  <= '0;
            lowPower_q <= 1'b0;
            tol_q      <= 12'h000;
        end else begin
            state_q    <= state_d;
            count_q    <= count_d;
            tickCnt_q  <= tickCnt_d;
            lowPower_q <= lowPower_d;
            tol_q      <= tol_d;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_RELOAD_1G: assert property (
        state_q == ST_BUSY && allIdle && !restore && linkSpeed == SPD_1G
        |=> state_q == ST_COUNT && count_q == $past(cfg_q.inactivityReload1g))
        else $error("Gigabit reload not loaded.");

    AST_RELOAD_100M: assert property (
        state_q == ST_BUSY && allIdle && !restore && linkSpeed == SPD_100M
        |=> count_q == $past(cfg_q.inactivityReload100m))
        else $error("100 Mbps reload not loaded.");

    AST_RELOAD_10M: assert property (
        state_q == ST_BUSY && allIdle && !restore && linkSpeed == SPD_10M
        |=> count_q == $past(cfg_q.inactivityReload10m))
        else $error("10 Mbps reload not loaded.");

    AST_NO_LOAD_DISABLED: assert property (
        state_q == ST_BUSY && !enable_q |=> state_q == ST_BUSY)
        else $error("Countdown started while disabled.");

    AST_STEP: assert property (
        state_q == ST_COUNT && allIdle && !restore && count_q != 16'h0000 && tick
        |=> count_q == $past(count_q) - 16'h0001)
        else $error("Countdown did not step by one.");

    AST_HOLD_BETWEEN_TICKS: assert property (
        state_q == ST_COUNT && !tick |=> $stable(count_q))
        else $error("Countdown moved between steps.");

    // Cycles since the last step, kept apart from the divider so a bad compare shows up.
    logic [TW-1:0] stepGap_q;
    always_ff @(posedge clock) begin
        stepGap_q <= (rst || tick || state_q != ST_COUNT) ? '0 : stepGap_q + 1'b1;
    end

    AST_TICK_SPACING: assert property (
        tick && state_q == ST_COUNT |-> stepGap_q == TW'(TICK_CYCLES - 1))
        else $error("Steps not spaced by the step period.");

    AST_ENTER_IDLE: assert property (
        state_q == ST_COUNT && allIdle && !restore && count_q == 16'h0000
        |=> lowPower_q && state_q == ST_LOWPWR)
        else $error("Idle latency state not entered at zero.");

    AST_ABANDON: assert property (
        !allIdle |=> !lowPower_q && state_q == ST_BUSY)
        else $error("Activity did not return the active state.");

    AST_TOL_IDLE10: assert property (
        state_q == ST_LOWPWR && linkSpeed == SPD_10M |=> tol_q == $past(cfg_q.idleTol10m))
        else $error("Idle 10 Mbps tolerance not selected.");

    AST_TOL_ACT10: assert property (
        state_q != ST_LOWPWR && linkSpeed == SPD_10M |=> tol_q == $past(cfg_q.activeTol10m))
        else $error("Active 10 Mbps tolerance not selected.");

    AST_TOL_ACT1G: assert property (
        state_q != ST_LOWPWR && linkSpeed == SPD_1G |=> tol_q == $past(cfg_q.activeTol1g))
        else $error("Active gigabit tolerance not selected.");

    AST_TOL_IDLE1G: assert property (
        state_q == ST_LOWPWR && linkSpeed == SPD_1G |=> tol_q == $past(cfg_q.idleTol1g))
        else $error("Idle gigabit tolerance not selected.");

    AST_RESTORE: assert property (
        restore |=> cfg_q == ($past(imageValid) ? $past(image) : ltm_image_s'(`LTM_RESET_VALUE))
                    && state_q == ST_BUSY)
        else $error("Reset did not restore the image.");

    AST_BUS_READY: assert property (
        psel && !penable ##1 psel && penable |-> !pready_q ##1 pready_q)
        else $error("APB ready not on the second access cycle.");

    COV_LOW_POWER: cover property (state_q == ST_COUNT ##1 state_q == ST_LOWPWR);
    COV_ABANDON: cover property (state_q == ST_COUNT ##1 state_q == ST_BUSY);
    COV_WAKE: cover property (state_q == ST_LOWPWR ##1 state_q == ST_BUSY);
    COV_RESTORE: cover property (restore && imageValid);
endmodule
`default_nettype wire

/* File: sim/ltm_host_model.sv */
// Behavioural model of the USB host that hears the selected latency tolerance.
`timescale 1ns/1ps
`default_nettype none
module ltm_host_model (
    input  wire logic        clock,     // 100 MHz clock.
    input  wire logic        rst,       // Synchronous reset, active high.
    input  wire logic        lowPower,  // Latency state from the device.
    input  wire logic [11:0] tolerance, // Tolerance offered by the device.
    output logic      [11:0] heardTol,  // Last tolerance the host took.
    output logic             heardLow,  // Last latency state the host took.
    output int unsigned      msgCount   // Number of updates heard.
);
    // ==========================================================
    // Message capture
    // The host only records changes, so a device that chatters shows up as extra messages.
    always @(posedge clock) begin
        if (rst) begin
            heardTol <= 12'h000;
            heardLow <= 1'b0;
            msgCount <= 0;
        end else if (tolerance !== heardTol || lowPower !== heardLow) begin
            heardTol <= tolerance;
            heardLow <= lowPower;
            msgCount <= msgCount + 1;
        end
    end
endmodule
`default_nettype wire

/* File: sim/ltm_latency_inactivity_timer_bench.sv */
// Self-checking bench for the latency inactivity timer.
`timescale 1ns/1ps
`default_nettype none
`include "ltm_regs.svh"
module ltm_latency_inactivity_timer_bench;
    import ltm_pkg::*;
    localparam int        TICK  = 4;
    localparam int        LIMIT = 20000;
    localparam datapath_s IDLE  = 5'b11110;
    logic        clock, rst, psel, penable, pwrite, pready, pslverr, err;
    logic        usbReset, liteReset, imageValid, lowPower, heardLow;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, seedQ, rd;
    logic [11:0] tolerance, heardTol;
    logic [127:0] big;
    ltm_image_s  image, cfg;
    datapath_s   dataPath;
    speed_e      linkSpeed;
    int          err_total, comparisons, cycles, n, r;
    int unsigned msgCount;

    ltm_latency_inactivity_timer #(.TICK_CYCLES(TICK)) u_dut (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .usbReset(usbReset), .liteReset(liteReset),
        .imageValid(imageValid), .image(image), .dataPath(dataPath),
        .linkSpeed(linkSpeed), .lowPower(lowPower), .tolerance(tolerance));
    ltm_host_model u_host (
        .clock(clock), .rst(rst), .lowPower(lowPower), .tolerance(tolerance),
        .heardTol(heardTol), .heardLow(heardLow), .msgCount(msgCount));

    // ==========================================================
    // Clock and hang guard
    initial clock = 1'b0;
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles >= LIMIT) begin
            err_total = err_total + 1;
            finish_test();
        end
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Reserved bits are expected to read back as zero.
    function automatic logic [31:0] regWord(input logic [7:0] a);
        case (a)
            `LTM_OFF_IDLE_FAST:  return {4'h0, cfg.idleTol1g, 4'h0, cfg.idleTol100m};
            `LTM_OFF_IDLE_SLOW:  return {20'h0, cfg.idleTol10m};
            `LTM_OFF_ACT_FAST:   return {4'h0, cfg.activeTol1g, 4'h0, cfg.activeTol100m};
            `LTM_OFF_ACT_SLOW:   return {20'h0, cfg.activeTol10m};
            `LTM_OFF_INACT_FAST: return {cfg.inactivityReload1g, cfg.inactivityReload100m};
            `LTM_OFF_INACT_SLOW: return {16'h0, cfg.inactivityReload10m};
            default:             return 32'h0;
        endcase
    endfunction
    function automatic logic [11:0] expTol(input logic low, input int s);
        case ({low, s[1:0]})
            3'b000:  return cfg.activeTol10m;
            3'b001:  return cfg.activeTol100m;
            3'b010:  return cfg.activeTol1g;
            3'b100:  return cfg.idleTol10m;
            3'b101:  return cfg.idleTol100m;
            default: return cfg.idleTol1g;
        endcase
    endfunction
    function automatic logic [15:0] reloadOf(input int s);
        return (s == 0) ? cfg.inactivityReload10m :
               (s == 1) ? cfg.inactivityReload100m : cfg.inactivityReload1g;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // One transfer, then an idle cycle so that no strobe is assigned twice in a time step.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic put(input logic [7:0] a, input logic [31:0] w);
        apb(1'b1, a, w);
        case (a)
            `LTM_OFF_IDLE_FAST:  {cfg.idleTol1g, cfg.idleTol100m} = {w[27:16], w[11:0]};
            `LTM_OFF_IDLE_SLOW:  cfg.idleTol10m = w[11:0];
            `LTM_OFF_ACT_FAST:   {cfg.activeTol1g, cfg.activeTol100m} = {w[27:16], w[11:0]};
            `LTM_OFF_ACT_SLOW:   cfg.activeTol10m = w[11:0];
            `LTM_OFF_INACT_FAST: {cfg.inactivityReload1g, cfg.inactivityReload100m} = w;
            `LTM_OFF_INACT_SLOW: cfg.inactivityReload10m = w[15:0];
            default:             ;
        endcase
    endtask
    task automatic chkAll(input string what);
        for (int a = 32'he0; a <= 32'hf4; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            check(rd, regWord(8'(a)), what);
        end
    endtask
    task automatic waitLow();
        n = 0;
        while (lowPower !== 1'b1 && n < 400) begin
            @(posedge clock);
            n++;
        end
    endtask
    task automatic finish_test();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {rst, psel, penable, pwrite, usbReset, liteReset, imageValid} = 7'b1000000;
        {paddr, pwdata, image, cfg} = '0;
        {err_total, comparisons, cycles} = '0;
        dataPath  = 5'b00001;
        linkSpeed = SPD_10M;
        seedQ     = 32'h265a8bf9;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int a = 32'he0; a <= 32'hfc; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            check(rd, 32'h0, "reset value");
        end
        $display("test reset values done");
        for (int i = 0; i < 3; i++) begin
            for (int a = 32'he0; a <= 32'hf4; a += 4) begin
                seedQ = lfsr(seedQ);
                put(8'(a), seedQ);
            end
            chkAll("readback");
        end
        apb(1'b0, 8'h10, 32'h0);
        check({rd[30:0], err}, 32'h1, "unmapped read");
        apb(1'b1, `LTM_OFF_STATUS, 32'hffffffff);
        apb(1'b0, `LTM_OFF_STATUS, 32'h0);
        check(rd, 32'h0, "status write ignored");
        $display("test register file done");
        // Small reloads keep the countdowns short while still being random.
        seedQ = lfsr(seedQ);
        put(`LTM_OFF_INACT_FAST, {13'h0, seedQ[2:0] | 3'h1, 13'h0, seedQ[5:3] | 3'h1});
        put(`LTM_OFF_INACT_SLOW, {29'h0, seedQ[8:6] | 3'h1});
        put(`LTM_OFF_CTRL, 32'h1);
        for (int s = 0; s < 3; s++) begin
            linkSpeed <= speed_e'(s);
            r = int'(reloadOf(s));
            repeat (3) @(posedge clock);
            check(32'(heardTol), 32'(expTol(1'b0, s)), "active tolerance");
            check(32'(heardLow), 32'h0, "host heard active");
            dataPath <= IDLE;
            repeat (r * TICK - 1) @(posedge clock);
            check(32'(lowPower), 32'h0, "early low power");
            seedQ = lfsr(seedQ);
            dataPath <= datapath_s'(IDLE ^ (5'h1 << (seedQ % 5)));
            repeat (3) @(posedge clock);
            check(32'(lowPower), 32'h0, "aborted countdown");
            dataPath <= IDLE;
            waitLow();
            check(32'(n / TICK), 32'(r),
                  "countdown length");
            repeat (3) @(posedge clock);
            check(32'(heardTol), 32'(expTol(1'b1, s)), "idle tolerance");
            check(32'(heardLow), 32'h1, "host heard idle");
            seedQ = lfsr(seedQ);
            dataPath <= datapath_s'(IDLE ^ (5'h1 << (seedQ % 5)));
            repeat (2) @(posedge clock);
            check(32'(lowPower), 32'h0, "wake on activity");
            $display("test speed %0d done", s);
        end
        // Every speed pass toggles the heard state twice, so fewer messages means lost updates.
        check(32'(msgCount >= 6), 32'h1, "host messages");
        put(`LTM_OFF_CTRL, 32'h0);
        dataPath <= IDLE;
        repeat (60) @(posedge clock);
        check(32'(lowPower), 32'h0, "disabled timer");
        put(`LTM_OFF_CTRL, 32'h1);
        waitLow();
        check(32'(lowPower), 32'h1, "re-enabled countdown");
        dataPath <= 5'b00001;
        for (int i = 0; i < 4; i++) begin
            seedQ = lfsr(seedQ);
            big = {big[95:0], seedQ};
        end
        image      <= ltm_image_s'(big[107:0]);
        imageValid <= 1'b1;
        usbReset   <= 1'b1;
        @(posedge clock);
        usbReset   <= 1'b0;
        cfg = ltm_image_s'(big[107:0]);
        @(posedge clock);
        check(32'(lowPower), 32'h0, "state after restore");
        chkAll("image restore");
        imageValid <= 1'b0;
        liteReset  <= 1'b1;
        @(posedge clock);
        liteReset  <= 1'b0;
        cfg = '0;
        chkAll("zero restore");
        dataPath <= IDLE;
        waitLow();
        check(32'(n <= 4), 32'h1, "zero reload");
        $display("test restore done");
        finish_test();
    end
endmodule
`default_nettype wire
